// >>> src/exec_pkg.sv
package exec_pkg;

    // ========================================================================
    // Opcode fields and constants
    // ========================================================================
    localparam logic [5:0] INCR_OPCODE = 6'h0A;
    localparam logic [5:0] SWAP_OPCODE = 6'h0E;
    localparam logic [10:0] DIRLOAD_PREFIX = 11'h00C;
    localparam logic [2:0] DIR_SEL_MIN = 3'h5;
    localparam logic [2:0] DIR_SEL_MAX = 3'h7;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] DIR_RESET = 8'hFF;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_INCR,
        OP_SWAP,
        OP_DIRLOAD
    } op_kind_t;

    // Result of one executed instruction, as seen by the register file.
    typedef struct packed {
        logic       acc_we;
        logic       file_we;
        logic [6:0] file_addr;
        logic [7:0] result;
        logic       zero_we;
        logic       zero;
        logic       dir_we;
        logic [1:0] dir_index;
        logic [7:0] dir_data;
    } exec_out_t;

endpackage

// >>> src/incr_swap_dirload_exec.sv
`timescale 1ns/10ps
module incr_swap_dirload_exec (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               instr_valid,
    input  wire logic [13:0]        instr,
    input  wire logic [7:0]         file_rdata,
    input  wire logic [7:0]         acc,
    output exec_pkg::exec_out_t     exec_out
);

    // ========================================================================
    // Decode
    // ========================================================================
    exec_pkg::op_kind_t kind;

    // True for a direction load word whose operand lies in the valid range.
    function automatic logic is_dir_load(input logic [13:0] word);
        logic prefix_ok;
        logic sel_ok;
        prefix_ok = (word[13:3] == exec_pkg::DIRLOAD_PREFIX);
        sel_ok    = (word[2:0] >= exec_pkg::DIR_SEL_MIN) &&
                    (word[2:0] <= exec_pkg::DIR_SEL_MAX);
        return prefix_ok && sel_ok;
    endfunction

    // True for a direction load word whose operand is below the valid range.
    // Such words are refused and must never reach a direction register.
    function automatic logic is_bad_dir_load(input logic [13:0] word);
        logic prefix_ok;
        prefix_ok = (word[13:3] == exec_pkg::DIRLOAD_PREFIX);
        return prefix_ok && (word[2:0] < exec_pkg::DIR_SEL_MIN);
    endfunction

    // Exchanges the two nibbles of a byte.
    function automatic logic [7:0] swap_nibbles(input logic [7:0] value);
        return {value[3:0], value[7:4]};
    endfunction

    always_comb
    begin
        kind = exec_pkg::OP_NONE;
        if (instr_valid)
        begin
            if (instr[13:8] == exec_pkg::INCR_OPCODE)
                kind = exec_pkg::OP_INCR;
            else if (instr[13:8] == exec_pkg::SWAP_OPCODE)
                kind = exec_pkg::OP_SWAP;
            else if (is_dir_load(instr))
                kind = exec_pkg::OP_DIRLOAD;
        end
    end

    // ========================================================================
    // Execute; the state is the registered result record
    // ========================================================================
    exec_pkg::exec_out_t state;
    exec_pkg::exec_out_t next_state;
    logic [7:0]          sum;

    assign sum = file_rdata + exec_pkg::BYTE_ONE;

    always_comb
    begin
        next_state = '0;
        next_state.file_addr = instr[6:0];
        case (kind)
            exec_pkg::OP_INCR:
            begin
                next_state.result  = sum;
                next_state.acc_we  = ~instr[7];
                next_state.file_we = instr[7];
                next_state.zero_we = 1'b1;
                next_state.zero    = (sum == exec_pkg::BYTE_RESET);
            end
            exec_pkg::OP_SWAP:
            begin
                next_state.result  = swap_nibbles(file_rdata);
                next_state.acc_we  = ~instr[7];
                next_state.file_we = instr[7];
            end
            exec_pkg::OP_DIRLOAD:
            begin
                // Direction registers stay file-addressable elsewhere too.
                next_state.dir_we    = 1'b1;
                next_state.dir_index = 2'(instr[2:0] - exec_pkg::DIR_SEL_MIN);
                next_state.dir_data  = acc;
            end
            default:
            begin
                next_state.file_addr = instr[6:0];
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            state <= '0;
        else
            state <= next_state;
    end

    assign exec_out = state;

    // ========================================================================
    // Checks
    // ========================================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_incr_sum_value: assert property (
        kind == exec_pkg::OP_INCR |=>
            exec_out.result == $past(file_rdata) + exec_pkg::BYTE_ONE)
        else $error("increment result wrong");
    a_incr_dest_sel: assert property (
        kind == exec_pkg::OP_INCR |=>
            exec_out.file_we == $past(instr[7]) &&
            exec_out.acc_we != exec_out.file_we)
        else $error("increment destination wrong");
    a_swap_nibble_order: assert property (
        kind == exec_pkg::OP_SWAP |=>
            exec_out.result[7:4] == $past(file_rdata[3:0]) &&
            exec_out.result[3:0] == $past(file_rdata[7:4]))
        else $error("swap result wrong");
    a_swap_dest_sel: assert property (
        kind == exec_pkg::OP_SWAP |=>
            exec_out.acc_we == !$past(instr[7]) && !exec_out.zero_we)
        else $error("swap destination wrong");
    a_dirload_copy_acc: assert property (
        kind == exec_pkg::OP_DIRLOAD |=>
            exec_out.dir_we && exec_out.dir_data == $past(acc) &&
            !exec_out.acc_we && !exec_out.file_we)
        else $error("direction load wrong");
    a_dirload_bad_sel: assert property (
        instr_valid && is_bad_dir_load(instr) |=>
            !exec_out.dir_we)
        else $error("invalid direction select accepted");
    a_dir_only_load: assert property (
        exec_out.dir_we |-> $past(kind) == exec_pkg::OP_DIRLOAD)
        else $error("direction write without load");
    a_zero_flag_set: assert property (
        exec_out.zero_we |-> $past(kind) == exec_pkg::OP_INCR &&
            exec_out.zero == (exec_out.result == exec_pkg::BYTE_RESET))
        else $error("zero flag wrong");

    // ========================================================================
    // Further checks on addressing, refusal and flag handling
    // ========================================================================
    a_file_addr_pass: assert property (
        (kind == exec_pkg::OP_INCR || kind == exec_pkg::OP_SWAP) |=>
            exec_out.file_addr == $past(instr[6:0]))
        else $error("file address not passed on");

    a_incr_wrap_zero: assert property (
        kind == exec_pkg::OP_INCR && file_rdata == 8'hFF |=>
            exec_out.zero && exec_out.zero_we &&
            exec_out.result == exec_pkg::BYTE_RESET)
        else $error("increment wrap did not set zero");

    a_incr_nonzero_clr: assert property (
        kind == exec_pkg::OP_INCR && file_rdata != 8'hFF |=>
            !exec_out.zero && exec_out.zero_we)
        else $error("increment left zero set");

    a_other_keep_flags: assert property (
        kind != exec_pkg::OP_INCR |=> !exec_out.zero_we)
        else $error("flag touched by non-increment");

    a_refused_quiet: assert property (
        kind == exec_pkg::OP_NONE |=>
            !exec_out.acc_we && !exec_out.file_we &&
            !exec_out.dir_we && !exec_out.zero_we)
        else $error("refused word produced a write");

    a_dirload_index: assert property (
        kind == exec_pkg::OP_DIRLOAD |=>
            $past(instr[2:0]) ==
                3'(exec_out.dir_index) + exec_pkg::DIR_SEL_MIN)
        else $error("direction index wrong");

    a_one_target: assert property (
        $onehot0({exec_out.acc_we, exec_out.file_we, exec_out.dir_we}))
        else $error("more than one write target");

    a_swap_to_file: assert property (
        kind == exec_pkg::OP_SWAP && instr[7] |=>
            exec_out.file_we && !exec_out.acc_we)
        else $error("swap did not store to file");

    // ========================================================================
    // Scenario covers
    // ========================================================================

    c_incr_wrap: cover property (
        kind == exec_pkg::OP_INCR && file_rdata == 8'hFF);
    c_swap_to_file: cover property (
        kind == exec_pkg::OP_SWAP && instr[7]);
    c_dirload_seven: cover property (
        kind == exec_pkg::OP_DIRLOAD && instr[2:0] == 3'h7);
    c_incr_to_acc: cover property (
        kind == exec_pkg::OP_INCR && !instr[7]);
    c_dirload_refused: cover property (
        instr_valid && is_bad_dir_load(instr));

endmodule // incr_swap_dirload_exec

// >>> testbench/regfile_model.sv
`timescale 1ns/10ps
// Register file and accumulator; writes land at the edge after the result.
module regfile_model (
    input  wire logic                mclk,
    input  wire logic [6:0]          addr,
    input  wire exec_pkg::exec_out_t eo,
    output logic [7:0]               file_rdata,
    output logic [7:0]               acc
);
    logic [7:0] mem [128];
    initial
    begin
        acc = 8'h3c;
        foreach (mem[k]) mem[k] = 8'hf0 + 8'(k);
    end
    assign file_rdata = mem[addr];
    always @(posedge mclk)
    begin
        if (eo.acc_we) acc <= eo.result;
        if (eo.file_we) mem[eo.file_addr] <= eo.result;
        if (eo.dir_we) mem[7'(eo.dir_index) + 7'h05] <= eo.dir_data;
    end
endmodule // regfile_model

// >>> testbench/incr_swap_dirload_exec_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module incr_swap_dirload_exec_test;
    logic                mclk = 0, rst = 1, instr_valid = 0;
    logic [13:0]         instr = 14'h0000;
    logic [7:0]          file_rdata, acc;
    logic [31:0]         lfsr = 32'h869d;
    int                  failures = 0, checks_done = 0;
    exec_pkg::exec_out_t exec_out, e;
    incr_swap_dirload_exec i_dut (.mclk(mclk), .rst(rst), .instr(instr),
        .instr_valid(instr_valid), .file_rdata(file_rdata), .acc(acc),
        .exec_out(exec_out));
    regfile_model i_rf (.mclk(mclk), .addr(instr[6:0]), .eo(exec_out),
        .file_rdata(file_rdata), .acc(acc));
    initial forever #4 mclk = ~mclk;
    function automatic logic [31:0] lfsr_next(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic exec_pkg::exec_out_t exp_of(logic v, logic [13:0] i,
        logic [7:0] r, logic [7:0] a);
        exec_pkg::exec_out_t x;
        logic inc, op;
        x = '0;
        inc = v && i[13:8] == exec_pkg::INCR_OPCODE;
        op = inc || (v && i[13:8] == exec_pkg::SWAP_OPCODE);
        x.file_addr = i[6:0];
        x.result = inc ? r + 8'h01 : {r[3:0], r[7:4]};
        x.zero_we = inc;
        x.zero = x.result == 8'h00;
        x.acc_we = op & ~i[7];
        x.file_we = op & i[7];
        x.dir_we = v && i[13:3] == 11'h00c && i[2:0] >= 3'h5;
        x.dir_index = 2'(i[2:0] - 3'h5);
        x.dir_data = a;
        return x;
    endfunction
    task automatic step(logic v, logic [13:0] i);
        @(negedge mclk);
        instr_valid = v;
        instr = i;
        #1 e = exp_of(v, i, file_rdata, acc);
        @(posedge mclk);
        #1;
        `CHK({exec_out.acc_we, exec_out.file_we, exec_out.dir_we},
            {e.acc_we, e.file_we, e.dir_we})
        `CHK(exec_out.zero_we, e.zero_we)
        if (e.acc_we | e.file_we)
            `CHK({exec_out.result, exec_out.file_addr}, {e.result, i[6:0]})
        if (e.zero_we) `CHK(exec_out.zero, e.zero)
        if (e.dir_we)
            `CHK({exec_out.dir_index, exec_out.dir_data},
                {e.dir_index, e.dir_data})
    endtask
    task close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        #1 `CHK(exec_out, exec_pkg::exec_out_t'(0))
        @(negedge mclk) rst = 0;
        step(1, 14'h0a8f);
        step(1, 14'h0e05);
        step(1, 14'h0e85);
        for (int s = 0; s < 8; s++) step(1, 14'h0060 + 14'(s));
        step(0, 14'h0a85);
        $display("directed test done");
        repeat (600)
        begin
            lfsr = lfsr_next(lfsr);
            case (lfsr[1:0])
                2'h0: step(1, {6'h0a, lfsr[9:2]});
                2'h1: step(1, {6'h0e, lfsr[9:2]});
                2'h2: step(1, {11'h00c, lfsr[4:2]});
                default: step(lfsr[16], lfsr[15:2]);
            endcase
        end
        $display("random test done");
        close_out;
    end
    initial
    begin
        #20000;
        failures++;
        close_out;
    end
endmodule // incr_swap_dirload_exec_test
